// >>> design/apr_top.sv
`timescale 1ns/1ps
`include "apr_defs.svh"
// Summary of operation
// - any write to word zero resets registers
// - reading word zero returns chip identification
// - speaker, left stage, oscillator enables reset off
// - bit 8 enables right headphone stage
// - divider select: off, normal, standby, fast
// - bit 0 enables bias generator
// - bit 15 reads overtemperature status
// - shutdown control disables outputs on overtemperature
// - sensor enable needed for thermal shutdown
// - bit 7 enables input one a amplifier
// - bit 6 enables input one b amplifier
module apr_top import apr_pkg::*; #(
    parameter logic [6:0]  DEV_ADDR = 7'h1A,    // bus slave address
    parameter logic [15:0] CHIP_ID  = 16'hC0DE  // identification word, value arbitrary
) (
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out_out,
    output logic            sda_oe_out,
    input  wire logic       overtemp_in,
    output logic            speaker_output_enable_out,
    output logic            left_phones_stage_enable_out,
    output logic            right_phones_stage_enable_out,
    output logic            internal_oscillator_enable_out,
    output logic [1:0]      reference_divider_select_out,
    output logic            bias_generator_enable_out,
    output logic            thermal_sensor_enable_out,
    output logic            input_one_a_amp_enable_out,
    output logic            input_one_b_amp_enable_out
);
    // the general call and reserved addresses cannot be served
    if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_bad_addr
        $error("DEV_ADDR falls in a reserved range");
    end

    apr_reg_if      rif ();                       // link to the register bank
    logic           scl_meta, scl_s, scl_d;       // clock pin synchroniser and delay
    logic           sda_meta, sda_s, sda_d;       // data pin synchroniser and delay
    logic           scl_rise, scl_fall;           // clock edges
    logic           start_seen, stop_seen;        // bus conditions
    apr_i2c_state_t state, next_state;            // transfer state
    logic [3:0]     bit_cnt, next_bit_cnt;        // bit within the byte
    logic [7:0]     shreg, next_shreg;            // receive and transmit shifter
    logic [7:0]     rx_byte;                      // byte with the bit now sampled
    logic [1:0]     byte_idx, next_byte_idx;      // byte position within a write
    logic [7:0]     reg_addr, next_reg_addr;      // register pointer
    logic [7:0]     data_hi, next_data_hi;        // upper write byte
    logic [7:0]     rd_lo, next_rd_lo;            // lower read byte
    logic           is_read, next_is_read;        // direction bit of the address
    logic           sda_oe, next_sda_oe;          // pull data low
    logic           wr_en, next_wr_en;            // write strobe
    logic [15:0]    wdata, next_wdata;            // write word

    // pin synchronisers; the second stage and its delayed copy feed logic
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_meta <= 1'b1;
            scl_s    <= 1'b1;
            scl_d    <= 1'b1;
            sda_meta <= 1'b1;
            sda_s    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_s    <= scl_meta;
            scl_d    <= scl_s;
            sda_meta <= sda_in;
            sda_s    <= sda_meta;
            sda_d    <= sda_s;
        end
    end

    // edge and condition detection
    assign scl_rise   = scl_s & ~scl_d;
    assign scl_fall   = ~scl_s & scl_d;
    assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

    // transfer state machine
    always_comb begin
        next_state    = state;
        next_bit_cnt  = bit_cnt;
        next_shreg    = shreg;
        next_byte_idx = byte_idx;
        next_reg_addr = reg_addr;
        next_data_hi  = data_hi;
        next_rd_lo    = rd_lo;
        next_is_read  = is_read;
        next_sda_oe   = sda_oe;
        next_wr_en    = 1'b0;
        next_wdata    = wdata;
        rx_byte       = {shreg[6:0], sda_s};
        if (start_seen) begin
            // start or repeated start, pointer kept
            next_state    = st_rx;
            next_bit_cnt  = 4'h0;
            next_byte_idx = 2'h0;
            next_sda_oe   = 1'b0;
        end else if (stop_seen) begin
            next_state  = st_idle;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                st_idle: begin
                    next_sda_oe = 1'b0;
                end
                st_rx: begin
                    if (scl_rise) begin
                        next_shreg   = rx_byte;
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            next_state   = st_ackw;
                            next_bit_cnt = 4'h0;
                            case (byte_idx)
                                2'h0: begin
                                    // foreign address: stay off the bus
                                    if (rx_byte[7:1] == DEV_ADDR) begin
                                        next_is_read = rx_byte[0];
                                    end else begin
                                        next_state = st_idle;
                                    end
                                end
                                2'h1: begin
                                    next_reg_addr = rx_byte;
                                end
                                2'h2: begin
                                    next_data_hi = rx_byte;
                                end
                                default: begin
                                    // a write to word zero is the soft reset
                                    next_wr_en = 1'b1;
                                    next_wdata = {data_hi, rx_byte};
                                end
                            endcase
                        end
                    end
                end
                st_ackw: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b1;
                        next_state  = st_ack;
                    end
                end
                st_ack: begin
                    if (scl_fall) begin
                        if (byte_idx == 2'h0 && is_read) begin
                            // read word sampled once, upper byte first
                            next_shreg  = rif.rdata[15:8];
                            next_rd_lo  = rif.rdata[7:0];
                            next_sda_oe = ~rif.rdata[15];
                            next_state  = st_tx;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state  = st_rx;
                        end
                        // further data pairs rewrite the same register
                        next_byte_idx = (byte_idx == 2'h3) ? 2'h2 : byte_idx + 2'h1;
                    end
                end
                st_tx: begin
                    if (scl_fall) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            next_sda_oe  = 1'b0;
                            next_bit_cnt = 4'h0;
                            next_state   = st_rack;
                        end else begin
                            next_shreg  = {shreg[6:0], 1'b0};
                            next_sda_oe = ~shreg[6];
                        end
                    end
                end
                st_rack: begin
                    // master acknowledge asks for the lower byte
                    if (scl_rise) begin
                        next_state = sda_s ? st_idle : st_nextb;
                    end
                end
                st_nextb: begin
                    if (scl_fall) begin
                        next_shreg  = rd_lo;
                        next_sda_oe = ~rd_lo[7];
                        next_state  = st_tx;
                    end
                end
                default: begin
                    next_state = st_idle;
                end
            endcase
        end
    end

    // transfer state registers
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state    <= st_idle;
            bit_cnt  <= 4'h0;
            shreg    <= 8'h00;
            byte_idx <= 2'h0;
            reg_addr <= 8'h00;
            data_hi  <= 8'h00;
            rd_lo    <= 8'h00;
            is_read  <= 1'b0;
            sda_oe   <= 1'b0;
            wr_en    <= 1'b0;
            wdata    <= 16'h0000;
        end else begin
            state    <= next_state;
            bit_cnt  <= next_bit_cnt;
            shreg    <= next_shreg;
            byte_idx <= next_byte_idx;
            reg_addr <= next_reg_addr;
            data_hi  <= next_data_hi;
            rd_lo    <= next_rd_lo;
            is_read  <= next_is_read;
            sda_oe   <= next_sda_oe;
            wr_en    <= next_wr_en;
            wdata    <= next_wdata;
        end
    end

    // open-drain data pin only ever pulls low
    assign sda_out_out = 1'b0;
    assign sda_oe_out  = sda_oe;
    assign rif.wr_en   = wr_en;
    assign rif.addr    = reg_addr;
    assign rif.wdata   = wdata;

    // register bank
    apr_regs #(
        .CHIP_ID (CHIP_ID)
    ) u_regs (
        .sys_clk_in                     (sys_clk_in),
        .reset_n_in                     (reset_n_in),
        .bus                            (rif),
        .overtemp_in                    (overtemp_in),
        .speaker_output_enable_out      (speaker_output_enable_out),
        .left_phones_stage_enable_out   (left_phones_stage_enable_out),
        .right_phones_stage_enable_out  (right_phones_stage_enable_out),
        .internal_oscillator_enable_out (internal_oscillator_enable_out),
        .reference_divider_select_out   (reference_divider_select_out),
        .bias_generator_enable_out      (bias_generator_enable_out),
        .thermal_sensor_enable_out      (thermal_sensor_enable_out),
        .input_one_a_amp_enable_out     (input_one_a_amp_enable_out),
        .input_one_b_amp_enable_out     (input_one_b_amp_enable_out)
    );

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_wr_pulse;
        wr_en |=> !wr_en;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");
    property p_id_load;
        (state == st_ack && scl_fall && byte_idx == 2'h0 && is_read && reg_addr == `APR_ADDR_CHIPID)
            |=> (shreg == CHIP_ID[15:8] && rd_lo == CHIP_ID[7:0]);
    endproperty
    a_id_load: assert property (p_id_load) else $error("identification not loaded");
    c_write: cover property (wr_en && reg_addr == `APR_ADDR_PWR1);
    c_read: cover property (state == st_rack ##[1:1000] state == st_nextb);
endmodule // apr_top

// >>> design/apr_defs.svh
`ifndef APR_DEFS_SVH
`define APR_DEFS_SVH

// register addresses on the control bus
`define APR_ADDR_CHIPID  8'h00
`define APR_ADDR_PWR1    8'h01
`define APR_ADDR_PWR2    8'h02

// first power register field positions
`define APR_P1_SPK       12
`define APR_P1_HPL       9
`define APR_P1_HPR       8
`define APR_P1_OSC       3
`define APR_P1_DIV_HI    2
`define APR_P1_DIV_LO    1
`define APR_P1_BIAS      0

// second power register field positions
`define APR_P2_STAT      15
`define APR_P2_TSE       14
`define APR_P2_OPD       13
`define APR_P2_INA       7
`define APR_P2_INB       6

// writable bit masks and reset values
`define APR_P1_WMASK     16'h130F
`define APR_P2_WMASK     16'h60C0
`define APR_P1_RST       16'h0006
`define APR_P2_RST       16'h6000

`endif

// >>> design/apr_pkg.sv
package apr_pkg;
    // serial control port states
    typedef enum logic [2:0] {
        st_idle,
        st_rx,
        st_ackw,
        st_ack,
        st_tx,
        st_rack,
        st_nextb
    } apr_i2c_state_t;
endpackage // apr_pkg

// >>> design/apr_reg_if.sv
`timescale 1ns/1ps
interface apr_reg_if;
    logic        wr_en;  // one-cycle write strobe
    logic [7:0]  addr;   // register address, held between accesses
    logic [15:0] wdata;  // write word, valid with wr_en
    logic [15:0] rdata;  // registered read word for addr
    modport ctrl (output wr_en, output addr, output wdata, input rdata);
    modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface // apr_reg_if

// >>> design/apr_regs.sv
`timescale 1ns/1ps
`include "apr_defs.svh"
module apr_regs import apr_pkg::*; #(
    parameter logic [15:0] CHIP_ID = 16'hC0DE  // identification word, value arbitrary
) (
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    apr_reg_if.regs         bus,
    input  wire logic       overtemp_in,
    output logic            speaker_output_enable_out,
    output logic            left_phones_stage_enable_out,
    output logic            right_phones_stage_enable_out,
    output logic            internal_oscillator_enable_out,
    output logic [1:0]      reference_divider_select_out,
    output logic            bias_generator_enable_out,
    output logic            thermal_sensor_enable_out,
    output logic            input_one_a_amp_enable_out,
    output logic            input_one_b_amp_enable_out
);
    logic [15:0] pwr1, next_pwr1;     // first power register
    logic [15:0] pwr2, next_pwr2;     // second power register, writable bits only
    logic [15:0] next_rdata;          // read word before its register
    logic        ot_meta, ot_sync;    // overtemp pin synchroniser
    logic        over, shut;          // sensed overtemp and output shutdown
    logic [8:0]  outs, next_outs;     // registered enables to the analogue side

    // read decode, unmapped words and bits read zero
    function automatic logic [15:0] apr_read(input logic [7:0] a, input logic [15:0] p1,
                                             input logic [15:0] p2, input logic st);
        logic [15:0] r;
        r = 16'h0000;
        if (a == `APR_ADDR_CHIPID) begin
            r = CHIP_ID;
        end else if (a == `APR_ADDR_PWR1) begin
            r = p1;
        end else if (a == `APR_ADDR_PWR2) begin
            r = p2;
            r[`APR_P2_STAT] = st;
        end
        return r;
    endfunction

    // next register state, outputs and read word
    always_comb begin
        next_pwr1 = pwr1;
        next_pwr2 = pwr2;
        if (bus.wr_en) begin
            if (bus.addr == `APR_ADDR_CHIPID) begin
                // any write word resets the control registers
                next_pwr1 = `APR_P1_RST;
                next_pwr2 = `APR_P2_RST;
            end else if (bus.addr == `APR_ADDR_PWR1) begin
                next_pwr1 = bus.wdata & `APR_P1_WMASK;
            end else if (bus.addr == `APR_ADDR_PWR2) begin
                next_pwr2 = bus.wdata & `APR_P2_WMASK;
            end
        end
        // status only while the sensor is on; shutdown also needs the control bit
        over = pwr2[`APR_P2_TSE] & ot_sync;
        shut = over & pwr2[`APR_P2_OPD];
        next_rdata = apr_read(bus.addr, pwr1, pwr2, over);
        next_outs[0] = pwr1[`APR_P1_SPK] & ~shut;
        next_outs[1] = pwr1[`APR_P1_HPL] & ~shut;
        next_outs[2] = pwr1[`APR_P1_HPR] & ~shut;
        next_outs[3] = pwr1[`APR_P1_OSC];
        next_outs[5:4] = pwr1[`APR_P1_DIV_HI:`APR_P1_DIV_LO];
        next_outs[6] = pwr1[`APR_P1_BIAS];
        next_outs[7] = pwr2[`APR_P2_INA];
        next_outs[8] = pwr2[`APR_P2_INB];
    end

    // register stage
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwr1      <= `APR_P1_RST;
            pwr2      <= `APR_P2_RST;
            bus.rdata <= 16'h0000;
            outs      <= 9'h030;
            ot_meta   <= 1'b0;
            ot_sync   <= 1'b0;
        end else begin
            pwr1      <= next_pwr1;
            pwr2      <= next_pwr2;
            bus.rdata <= next_rdata;
            outs      <= next_outs;
            ot_meta   <= overtemp_in;
            ot_sync   <= ot_meta;
        end
    end

    assign speaker_output_enable_out      = outs[0];
    assign left_phones_stage_enable_out   = outs[1];
    assign right_phones_stage_enable_out  = outs[2];
    assign internal_oscillator_enable_out = outs[3];
    assign reference_divider_select_out   = outs[5:4];
    assign bias_generator_enable_out      = outs[6];
    assign input_one_a_amp_enable_out     = outs[7];
    assign input_one_b_amp_enable_out     = outs[8];
    assign thermal_sensor_enable_out      = pwr2[`APR_P2_TSE];

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_soft_reset;
        (bus.wr_en && bus.addr == `APR_ADDR_CHIPID) |=> (pwr1 == `APR_P1_RST && pwr2 == `APR_P2_RST);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");
    property p_chip_id;
        (bus.addr == `APR_ADDR_CHIPID) |=> (bus.rdata == CHIP_ID);
    endproperty
    a_chip_id: assert property (p_chip_id) else $error("chip id wrong");
    property p_bank_enables;
        (bus.wr_en && bus.addr == `APR_ADDR_PWR1 && !shut) ##1 !shut |=>
            (speaker_output_enable_out == $past(bus.wdata[12], 2)
             && left_phones_stage_enable_out == $past(bus.wdata[9], 2)
             && internal_oscillator_enable_out == $past(bus.wdata[3], 2));
    endproperty
    a_bank_enables: assert property (p_bank_enables) else $error("enable bits wrong");
    property p_right_stage;
        (pwr1[`APR_P1_HPR] && !shut) |=> right_phones_stage_enable_out;
    endproperty
    a_right_stage: assert property (p_right_stage) else $error("right stage off");
    property p_divider;
        (bus.wr_en && bus.addr == `APR_ADDR_PWR1) |=> ##1
            (reference_divider_select_out == $past(bus.wdata[2:1], 2));
    endproperty
    a_divider: assert property (p_divider) else $error("divider select wrong");
    property p_bias;
        (bus.wr_en && bus.addr == `APR_ADDR_PWR1) |=> ##1 (bias_generator_enable_out == $past(bus.wdata[0], 2));
    endproperty
    a_bias: assert property (p_bias) else $error("bias enable wrong");
    property p_status;
        (bus.addr == `APR_ADDR_PWR2) |=> (bus.rdata[15] == $past(ot_sync && pwr2[`APR_P2_TSE]));
    endproperty
    a_status: assert property (p_status) else $error("thermal status wrong");
    property p_shutdown;
        (ot_sync && pwr2[`APR_P2_TSE] && pwr2[`APR_P2_OPD]) |=>
            !(speaker_output_enable_out || left_phones_stage_enable_out || right_phones_stage_enable_out);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("outputs not shut down");
    property p_sensor_off;
        !pwr2[`APR_P2_TSE] |=> (speaker_output_enable_out == $past(pwr1[12]));
    endproperty
    a_sensor_off: assert property (p_sensor_off) else $error("shutdown without sensor");
    property p_in_a;
        (bus.wr_en && bus.addr == `APR_ADDR_PWR2) |=> ##1 (input_one_a_amp_enable_out == $past(bus.wdata[7], 2));
    endproperty
    a_in_a: assert property (p_in_a) else $error("input a enable wrong");
    property p_in_b;
        (bus.wr_en && bus.addr == `APR_ADDR_PWR2) |=> ##1 (input_one_b_amp_enable_out == $past(bus.wdata[6], 2));
    endproperty
    a_in_b: assert property (p_in_b) else $error("input b enable wrong");
    property p_unmapped;
        (bus.addr > `APR_ADDR_PWR2) |=> (bus.rdata == 16'h0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    c_soft_reset: cover property (bus.wr_en && bus.addr == `APR_ADDR_CHIPID);
    c_shutdown: cover property (shut ##1 !shut);
    c_status_read: cover property (bus.addr == `APR_ADDR_PWR2 && over);
endmodule // apr_regs

// >>> sim/apr_host.sv
`timescale 1ns/1ps
// host model on the two-wire bus; a released data line is pulled high
module apr_host (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_rel_out
);
    initial begin
        scl_out = 1'b1;
        sda_rel_out = 1'b1;
    end
    // one bus phase, well above four system clocks
    task automatic put(input logic c, input logic d);
        scl_out = c;
        sda_rel_out = d;
        repeat (6) @(negedge clk_in);
    endtask
    // data changes only while the bus clock is low
    task automatic bitx(input logic b, output logic r);
        put(1'b0, sda_rel_out);
        put(1'b0, b);
        put(1'b1, b);
        r = sda_in;
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        put(1'b0, sda_rel_out);
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
    endtask
    // stop: data rises while clock high
    task automatic stop();
        put(1'b0, sda_rel_out);
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(am, ak);
    endtask
endmodule // apr_host

// >>> sim/apr_top_tb.sv
`timescale 1ns/1ps
`include "apr_defs.svh"
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin n_fail++; \
    $display("wrong value %s exp %h seen %h", nm, e, s); end end
module apr_top_tb import apr_pkg::*;;
    localparam logic [15:0] CHIP_ID = 16'hA5C3; // identification word, value arbitrary
    logic        sys_clk_in  = 1'b0;
    logic        reset_n_in  = 1'b0;
    logic        overtemp_in = 1'b0;
    logic        scl, sda_rel, sda_oe, sda_o;
    logic [9:0]  en;                       // all enable outputs
    wire         sda = sda_rel & ~(sda_oe & ~sda_o);  // pull-up, device can only pull the line low
    int          n_fail = 0;
    int          n_compared = 0;
    int          seed = 14812;
    logic [15:0] exq[$];                   // expected results, oldest first
    logic [15:0] seen, exp_w, r1, r2, w;
    event        res_ev;
    always #12.5 sys_clk_in = ~sys_clk_in;
    apr_host host (.clk_in(sys_clk_in), .sda_in(sda), .scl_out(scl), .sda_rel_out(sda_rel));
    apr_top #(.CHIP_ID(CHIP_ID)) uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .scl_in(scl),
        .sda_in(sda), .sda_out_out(sda_o), .sda_oe_out(sda_oe), .overtemp_in(overtemp_in),
        .speaker_output_enable_out(en[9]), .left_phones_stage_enable_out(en[8]),
        .right_phones_stage_enable_out(en[7]), .internal_oscillator_enable_out(en[6]),
        .reference_divider_select_out(en[5:4]), .bias_generator_enable_out(en[3]),
        .thermal_sensor_enable_out(en[2]), .input_one_a_amp_enable_out(en[1]),
        .input_one_b_amp_enable_out(en[0]));
    // register write: device byte, address byte, then word high first
    task automatic wr(input logic [7:0] dv, input logic [7:0] a, input logic [15:0] d);
        logic [7:0] q;
        logic [3:0] k;
        exq.push_back({12'h000, {4{dv[7:1] != 7'h1A}}}); // only our own address is acknowledged
        host.start();
        host.xfer(dv, 1'b1, q, k[3]);
        host.xfer(a, 1'b1, q, k[2]);
        host.xfer(d[15:8], 1'b1, q, k[1]);
        host.xfer(d[7:0], 1'b1, q, k[0]);
        host.stop();
        seen = {12'h000, k};
        -> res_ev;
    endtask
    // register read through a repeated start
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [7:0] h, l;
        logic       k;
        exq.push_back(e);
        host.start();
        host.xfer(8'h34, 1'b1, h, k);
        host.xfer(a, 1'b1, h, k);
        host.start();
        host.xfer(8'h35, 1'b1, h, k);
        host.xfer(8'hFF, 1'b0, h, k);
        host.xfer(8'hFF, 1'b1, l, k);
        host.stop();
        seen = {h, l};
        -> res_ev;
    endtask
    // enable outputs expected from both register words
    task automatic chk_out(input logic [15:0] p1, input logic [15:0] p2, input logic ot);
        logic sd;
        sd = ot & p2[14] & p2[13]; // cut needs sensor and shutdown both on
        exq.push_back({6'h00, p1[12] & ~sd, p1[9] & ~sd, p1[8] & ~sd, p1[3], p1[2:1], p1[0], p2[14], p2[7], p2[6]});
        @(negedge sys_clk_in);
        seen = {6'h00, en};
        -> res_ev;
    endtask
    // compare each result with the oldest note
    always @(res_ev) begin
        exp_w = exq.pop_front();
        `CHK("result", exp_w, seen)
    end
    task automatic stop_test();
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk_in);
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge sys_clk_in);
        reset_n_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        rd(`APR_ADDR_CHIPID, CHIP_ID);
        rd(`APR_ADDR_PWR1, `APR_P1_RST);
        rd(`APR_ADDR_PWR2, `APR_P2_RST);
        chk_out(`APR_P1_RST, `APR_P2_RST, 1'b0);
        for (int i = 0; i < 8; i++) begin
            r1 = 16'($random(seed));
            r2 = 16'($random(seed));
            r1[2:1] = i[1:0]; // every divider code
            r2[14] = (i != 5);
            r2[13] = (i != 6);
            overtemp_in = i[0] | (i > 4);
            wr(8'h34, `APR_ADDR_PWR1, r1);
            wr(8'h34, `APR_ADDR_PWR2, r2);
            rd(`APR_ADDR_PWR1, r1 & `APR_P1_WMASK);
            rd(`APR_ADDR_PWR2, (r2 & `APR_P2_WMASK) | {overtemp_in & r2[14], 15'h0000});
            chk_out(r1, r2, overtemp_in);
        end
        w = 16'($random(seed));
        wr(8'h34, `APR_ADDR_CHIPID, w);
        rd(`APR_ADDR_PWR1, `APR_P1_RST);
        rd(`APR_ADDR_PWR2, `APR_P2_RST | {overtemp_in, 15'h0000});
        rd(8'h05, 16'h0000);
        chk_out(`APR_P1_RST, `APR_P2_RST, overtemp_in);
        // a foreign device address is ignored and leaves the registers alone
        wr(8'h36, `APR_ADDR_PWR1, 16'hFFFF);
        rd(`APR_ADDR_PWR1, `APR_P1_RST);
        // let the last comparison finish before the verdict
        @(negedge sys_clk_in);
        stop_test();
    end
endmodule // apr_top_tb
